// *** verilog/tkp_device.sv ***
`timescale 1ns/100ps
module tkp_device
  import tkp_pkg::*;
#(
  parameter bit HAS_MDIO   = 1'b1,
  parameter int CORE_DEPTH = 16
) (
  input  wire logic                  mclk_in,
  input  wire logic                  rst_n_in,
  tkp_port_if.dev                    port_if,
  output      logic [CFG_ADDR_W-1:0] xcvr_addr_out,
  output      logic                  xcvr_en_out,
  output      logic [WORD_W-1:0]     xcvr_wdata_out,
  output      logic                  xcvr_we_out,
  input  wire logic [WORD_W-1:0]     xcvr_rdata_in,
  input  wire logic                  xcvr_ready_in
);

  // ************************************************************
  // state
  // ************************************************************
  tkp_dev_state_t        state_r,    state_nxt;
  logic                  strobe_d_r;
  logic [ACC_ADDR_W-1:0] addr_r,     addr_nxt;
  logic                  rnw_r,      rnw_nxt;
  logic [WORD_W-1:0]     wword_r,    wword_nxt;
  logic                  core_hit_r, core_hit_nxt;
  logic [WORD_W-1:0]     rword_r,    rword_nxt;
  logic                  rack_r,     rack_nxt;
  logic                  wack_r,     wack_nxt;
  logic                  req_r,      req_nxt;
  logic [CFG_ADDR_W-1:0] caddr_r,    caddr_nxt;
  logic                  cen_r,      cen_nxt;
  logic [WORD_W-1:0]     cwdata_r,   cwdata_nxt;
  logic                  cwe_r,      cwe_nxt;
  logic                  mem_we;
  logic                  start;
  logic [WORD_W-1:0]     core_mem_r [CORE_DEPTH];

  // training signals come from logic on this clock, so no synchroniser
  assign start = port_if.access_strobe && !strobe_d_r;

  // ************************************************************
  // access sequencer
  // ************************************************************
  always_comb begin
    state_nxt    = state_r;
    addr_nxt     = addr_r;
    rnw_nxt      = rnw_r;
    wword_nxt    = wword_r;
    core_hit_nxt = core_hit_r;
    rword_nxt    = rword_r;
    rack_nxt     = 1'b0;
    wack_nxt     = 1'b0;
    req_nxt      = req_r;
    caddr_nxt    = caddr_r;
    cen_nxt      = 1'b0;
    cwdata_nxt   = cwdata_r;
    cwe_nxt      = cwe_r;
    mem_we       = 1'b0;
    case (state_r)
      TKP_IDLE: begin
        if (start) begin
          addr_nxt     = port_if.access_address;
          rnw_nxt      = port_if.read_not_write;
          wword_nxt    = port_if.access_write_word;
          // without the management option the core select is dead
          core_hit_nxt = port_if.core_reg_select && HAS_MDIO;
          if (port_if.xcvr_reg_select) begin
            req_nxt   = 1'b1;
            state_nxt = TKP_REQ;
          end else begin
            state_nxt = TKP_CORE;
          end
        end
      end
      TKP_CORE: begin
        // unselected accesses still complete so the trainer never hangs
        if (rnw_r) begin
          rword_nxt = core_hit_r ? core_mem_r[tkp_core_idx(addr_r)] : WORD_RST;
          rack_nxt  = 1'b1;
        end else begin
          mem_we    = core_hit_r;
          wack_nxt  = 1'b1;
        end
        state_nxt = TKP_IDLE;
      end
      TKP_REQ: begin
        if (port_if.port_grant) begin
          caddr_nxt  = addr_r[CFG_ADDR_W-1:0];
          cwdata_nxt = wword_r;
          cwe_nxt    = !rnw_r;
          cen_nxt    = 1'b1;
          state_nxt  = TKP_WAIT;
        end
      end
      TKP_WAIT: begin
        if (port_if.cfg_ready_in) begin
          req_nxt   = 1'b0;
          cwe_nxt   = 1'b0;
          state_nxt = TKP_IDLE;
          if (rnw_r) begin
            rword_nxt = port_if.cfg_rdata_in;
            rack_nxt  = 1'b1;
          end else begin
            wack_nxt  = 1'b1;
          end
        end
      end
      default: begin
        state_nxt = TKP_IDLE;
        req_nxt   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r    <= TKP_IDLE;
      strobe_d_r <= 1'b0;
      addr_r     <= ADDR_RST;
      rnw_r      <= 1'b0;
      wword_r    <= WORD_RST;
      core_hit_r <= 1'b0;
      rword_r    <= WORD_RST;
      rack_r     <= 1'b0;
      wack_r     <= 1'b0;
      req_r      <= 1'b0;
      caddr_r    <= CFG_RST;
      cen_r      <= 1'b0;
      cwdata_r   <= WORD_RST;
      cwe_r      <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      strobe_d_r <= port_if.access_strobe;
      addr_r     <= addr_nxt;
      rnw_r      <= rnw_nxt;
      wword_r    <= wword_nxt;
      core_hit_r <= core_hit_nxt;
      rword_r    <= rword_nxt;
      rack_r     <= rack_nxt;
      wack_r     <= wack_nxt;
      req_r      <= req_nxt;
      caddr_r    <= caddr_nxt;
      cen_r      <= cen_nxt;
      cwdata_r   <= cwdata_nxt;
      cwe_r      <= cwe_nxt;
    end
  end

  // ************************************************************
  // core register store
  // ************************************************************
  // stands in for the management register space; only low index bits decode
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < CORE_DEPTH; i++) begin
        core_mem_r[i] <= WORD_RST;
      end
    end else if (mem_we) begin
      core_mem_r[tkp_core_idx(addr_r)] <= wword_r;
    end
  end

  // ************************************************************
  // user-side pass-through
  // ************************************************************
  // registered both ways: one cycle of added latency buys clean outputs
  logic [CFG_ADDR_W-1:0] uaddr_r,  uaddr_nxt;
  logic                  uen_r,    uen_nxt;
  logic [WORD_W-1:0]     uwdata_r, uwdata_nxt;
  logic                  uwe_r,    uwe_nxt;
  logic [WORD_W-1:0]     urdata_r, urdata_nxt;
  logic                  urdy_r,   urdy_nxt;

  always_comb begin
    uaddr_nxt  = port_if.cfg_addr_in;
    uen_nxt    = port_if.cfg_en_in;
    uwdata_nxt = port_if.cfg_wdata_in;
    uwe_nxt    = port_if.cfg_we_in;
    urdata_nxt = xcvr_rdata_in;
    urdy_nxt   = xcvr_ready_in;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      uaddr_r  <= CFG_RST;
      uen_r    <= 1'b0;
      uwdata_r <= WORD_RST;
      uwe_r    <= 1'b0;
      urdata_r <= WORD_RST;
      urdy_r   <= 1'b0;
    end else begin
      uaddr_r  <= uaddr_nxt;
      uen_r    <= uen_nxt;
      uwdata_r <= uwdata_nxt;
      uwe_r    <= uwe_nxt;
      urdata_r <= urdata_nxt;
      urdy_r   <= urdy_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign port_if.access_read_word = rword_r;
  assign port_if.read_ack         = rack_r;
  assign port_if.write_ack        = wack_r;
  assign port_if.port_request     = req_r;
  assign port_if.cfg_addr_out     = caddr_r;
  assign port_if.cfg_en_out       = cen_r;
  assign port_if.cfg_wdata_out    = cwdata_r;
  assign port_if.cfg_we_out       = cwe_r;
  assign port_if.cfg_rdata_out    = urdata_r;
  assign port_if.cfg_ready_out    = urdy_r;
  assign xcvr_addr_out            = uaddr_r;
  assign xcvr_en_out              = uen_r;
  assign xcvr_wdata_out           = uwdata_r;
  assign xcvr_we_out              = uwe_r;

endmodule

// *** verilog/tkp_pkg.sv ***
package tkp_pkg;

  // ************************************************************
  // widths and field positions
  // ************************************************************
  localparam int ACC_ADDR_W   = 21;
  localparam int DEVAD_HI     = 20;
  localparam int DEVAD_LO     = 16;
  localparam int WORD_W       = 16;
  localparam int CFG_ADDR_W   = 16;
  localparam int CORE_IDX_W   = 4;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [WORD_W-1:0]     WORD_RST = 16'h0000;
  localparam logic [CFG_ADDR_W-1:0] CFG_RST  = 16'h0000;
  localparam logic [ACC_ADDR_W-1:0] ADDR_RST = 21'h000000;

  typedef enum logic [2:0] {
    TKP_IDLE,
    TKP_CORE,
    TKP_REQ,
    TKP_WAIT
  } tkp_dev_state_t;

  typedef enum logic [1:0] {
    TKP_T_IDLE,
    TKP_T_BUSY,
    TKP_T_GAP
  } tkp_trn_state_t;

  // device address field of a clause-45 access
  function automatic logic [DEVAD_HI-DEVAD_LO:0] tkp_devad(input logic [ACC_ADDR_W-1:0] a);
    tkp_devad = a[DEVAD_HI:DEVAD_LO];
  endfunction

  // index into the core register store
  function automatic logic [CORE_IDX_W-1:0] tkp_core_idx(input logic [ACC_ADDR_W-1:0] a);
    tkp_core_idx = a[CORE_IDX_W-1:0];
  endfunction

endpackage

// *** verilog/tkp_port_if.sv ***
`timescale 1ns/100ps
interface tkp_port_if;
  import tkp_pkg::*;

  logic                  access_strobe;
  logic [ACC_ADDR_W-1:0] access_address;
  logic                  read_not_write;
  logic                  core_reg_select;
  logic                  xcvr_reg_select;
  logic [WORD_W-1:0]     access_write_word;
  logic [WORD_W-1:0]     access_read_word;
  logic                  read_ack;
  logic                  write_ack;
  logic                  port_request;
  logic                  port_grant;
  logic [CFG_ADDR_W-1:0] cfg_addr_out;
  logic                  cfg_en_out;
  logic [WORD_W-1:0]     cfg_wdata_out;
  logic                  cfg_we_out;
  logic [WORD_W-1:0]     cfg_rdata_in;
  logic                  cfg_ready_in;
  logic [CFG_ADDR_W-1:0] cfg_addr_in;
  logic                  cfg_en_in;
  logic [WORD_W-1:0]     cfg_wdata_in;
  logic                  cfg_we_in;
  logic [WORD_W-1:0]     cfg_rdata_out;
  logic                  cfg_ready_out;

  modport dev (
    input  access_strobe, access_address, read_not_write, core_reg_select,
    input  xcvr_reg_select, access_write_word, port_grant, cfg_rdata_in, cfg_ready_in,
    input  cfg_addr_in, cfg_en_in, cfg_wdata_in, cfg_we_in,
    output access_read_word, read_ack, write_ack, port_request,
    output cfg_addr_out, cfg_en_out, cfg_wdata_out, cfg_we_out, cfg_rdata_out, cfg_ready_out
  );

  modport trn (
    output access_strobe, access_address, read_not_write, core_reg_select,
    output xcvr_reg_select, access_write_word, port_grant, cfg_rdata_in, cfg_ready_in,
    output cfg_addr_in, cfg_en_in, cfg_wdata_in, cfg_we_in,
    input  access_read_word, read_ack, write_ack, port_request,
    input  cfg_addr_out, cfg_en_out, cfg_wdata_out, cfg_we_out, cfg_rdata_out, cfg_ready_out
  );

endinterface

// *** verilog/tkp_trainer.sv ***
`timescale 1ns/100ps
module tkp_trainer
  import tkp_pkg::*;
(
  input  wire logic                  mclk_in,
  input  wire logic                  rst_n_in,
  tkp_port_if.trn                    port_if,
  input  wire logic                  cmd_valid_in,
  input  wire logic                  cmd_rnw_in,
  input  wire logic                  cmd_core_in,
  input  wire logic [ACC_ADDR_W-1:0] cmd_addr_in,
  input  wire logic [WORD_W-1:0]     cmd_wdata_in,
  output      logic                  cmd_ready_out,
  output      logic                  rsp_valid_out,
  output      logic [WORD_W-1:0]     rsp_rdata_out
);

  // ************************************************************
  // training access driver
  // ************************************************************
  tkp_trn_state_t        state_r, state_nxt;
  logic                  stb_r,   stb_nxt;
  logic                  csel_r,  csel_nxt;
  logic                  xsel_r,  xsel_nxt;
  logic                  rnw_r,   rnw_nxt;
  logic [ACC_ADDR_W-1:0] addr_r,  addr_nxt;
  logic [WORD_W-1:0]     wd_r,    wd_nxt;
  logic                  rdy_r,   rdy_nxt;
  logic                  rv_r,    rv_nxt;
  logic [WORD_W-1:0]     rd_r,    rd_nxt;

  always_comb begin
    state_nxt = state_r;
    stb_nxt   = stb_r;
    csel_nxt  = csel_r;
    xsel_nxt  = xsel_r;
    rnw_nxt   = rnw_r;
    addr_nxt  = addr_r;
    wd_nxt    = wd_r;
    rdy_nxt   = rdy_r;
    rv_nxt    = 1'b0;
    rd_nxt    = rd_r;
    case (state_r)
      TKP_T_IDLE: begin
        if (cmd_valid_in && rdy_r) begin
          stb_nxt   = 1'b1;
          csel_nxt  = cmd_core_in;
          xsel_nxt  = !cmd_core_in;
          rnw_nxt   = cmd_rnw_in;
          addr_nxt  = cmd_addr_in;
          wd_nxt    = cmd_wdata_in;
          rdy_nxt   = 1'b0;
          state_nxt = TKP_T_BUSY;
        end
      end
      TKP_T_BUSY: begin
        if (port_if.read_ack || port_if.write_ack) begin
          rd_nxt    = port_if.access_read_word;
          rv_nxt    = 1'b1;
          stb_nxt   = 1'b0;
          csel_nxt  = 1'b0;
          xsel_nxt  = 1'b0;
          state_nxt = TKP_T_GAP;
        end
      end
      TKP_T_GAP: begin
        // at least two low cycles (gap, then idle) so the next strobe is a fresh edge
        rdy_nxt   = 1'b1;
        state_nxt = TKP_T_IDLE;
      end
      default: begin
        state_nxt = TKP_T_IDLE;
        stb_nxt   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= TKP_T_IDLE;
      stb_r   <= 1'b0;
      csel_r  <= 1'b0;
      xsel_r  <= 1'b0;
      rnw_r   <= 1'b0;
      addr_r  <= ADDR_RST;
      wd_r    <= WORD_RST;
      rdy_r   <= 1'b1;
      rv_r    <= 1'b0;
      rd_r    <= WORD_RST;
    end else begin
      state_r <= state_nxt;
      stb_r   <= stb_nxt;
      csel_r  <= csel_nxt;
      xsel_r  <= xsel_nxt;
      rnw_r   <= rnw_nxt;
      addr_r  <= addr_nxt;
      wd_r    <= wd_nxt;
      rdy_r   <= rdy_nxt;
      rv_r    <= rv_nxt;
      rd_r    <= rd_nxt;
    end
  end

  // ************************************************************
  // single-user arbiter
  // ************************************************************
  // only one requester, so grant simply follows request a cycle later
  logic                  gnt_r;
  logic                  gnt_nxt;
  logic [CFG_ADDR_W-1:0] faddr_r, faddr_nxt;
  logic                  fen_r,   fen_nxt;
  logic [WORD_W-1:0]     fwd_r,   fwd_nxt;
  logic                  fwe_r,   fwe_nxt;
  logic [WORD_W-1:0]     brd_r,   brd_nxt;
  logic                  brdy_r,  brdy_nxt;

  always_comb begin
    gnt_nxt   = port_if.port_request;
    faddr_nxt = port_if.cfg_addr_out;
    fen_nxt   = port_if.cfg_en_out && gnt_r;
    fwd_nxt   = port_if.cfg_wdata_out;
    fwe_nxt   = port_if.cfg_we_out && gnt_r;
    brd_nxt   = port_if.cfg_rdata_out;
    brdy_nxt  = port_if.cfg_ready_out && gnt_r;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gnt_r  <= 1'b0;
      faddr_r <= CFG_RST;
      fen_r  <= 1'b0;
      fwd_r  <= WORD_RST;
      fwe_r  <= 1'b0;
      brd_r  <= WORD_RST;
      brdy_r <= 1'b0;
    end else begin
      gnt_r  <= gnt_nxt;
      faddr_r <= faddr_nxt;
      fen_r  <= fen_nxt;
      fwd_r  <= fwd_nxt;
      fwe_r  <= fwe_nxt;
      brd_r  <= brd_nxt;
      brdy_r <= brdy_nxt;
    end
  end

  assign port_if.access_strobe     = stb_r;
  assign port_if.access_address    = addr_r;
  assign port_if.read_not_write    = rnw_r;
  assign port_if.core_reg_select   = csel_r;
  assign port_if.xcvr_reg_select   = xsel_r;
  assign port_if.access_write_word = wd_r;
  assign port_if.port_grant        = gnt_r;
  assign port_if.cfg_addr_in       = faddr_r;
  assign port_if.cfg_en_in         = fen_r;
  assign port_if.cfg_wdata_in      = fwd_r;
  assign port_if.cfg_we_in         = fwe_r;
  assign port_if.cfg_rdata_in      = brd_r;
  assign port_if.cfg_ready_in      = brdy_r;
  assign cmd_ready_out             = rdy_r;
  assign rsp_valid_out             = rv_r;
  assign rsp_rdata_out             = rd_r;

endmodule

// *** dv/tkp_port_props.sv ***
`timescale 1ns/100ps
module tkp_port_props
  import tkp_pkg::*;
(
  input wire logic                  mclk_in,
  input wire logic                  rst_n_in,
  input wire logic                  access_strobe,
  input wire logic [ACC_ADDR_W-1:0] access_address,
  input wire logic                  read_not_write,
  input wire logic                  core_reg_select,
  input wire logic                  xcvr_reg_select,
  input wire logic                  read_ack,
  input wire logic                  write_ack,
  input wire logic                  port_request,
  input wire logic                  port_grant,
  input wire logic [CFG_ADDR_W-1:0] cfg_addr_out,
  input wire logic                  cfg_en_out,
  input wire logic                  cfg_we_out,
  input wire logic                  cfg_ready_in,
  input wire logic [CFG_ADDR_W-1:0] cfg_addr_in,
  input wire logic                  cfg_en_in,
  input wire logic [WORD_W-1:0]     cfg_rdata_out,
  input wire logic [CFG_ADDR_W-1:0] xcvr_addr_out,
  input wire logic                  xcvr_en_out,
  input wire logic [WORD_W-1:0]     xcvr_rdata_in
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  // ************************************************************
  // training port
  // ************************************************************
  chk_rack_single: assert property (read_ack |=> !read_ack)
    else $error("read ack longer than one cycle");
  chk_wack_single: assert property (write_ack |=> !write_ack)
    else $error("write ack longer than one cycle");
  chk_ack_in_access: assert property ((read_ack || write_ack) |-> access_strobe && !(read_ack && write_ack))
    else $error("ack outside a held access");
  chk_core_ack_time: assert property ($rose(access_strobe) && core_reg_select && !xcvr_reg_select
    |-> ##[1:2] (read_not_write ? read_ack : write_ack))
    else $error("core access ack late or wrong kind");
  chk_xcvr_done: assert property ($rose(port_request) |-> ##[3:60] (read_ack || write_ack))
    else $error("transceiver access never acknowledged");

  // ************************************************************
  // config master and pass-through
  // ************************************************************
  chk_en_pulse: assert property (cfg_en_out |=> !cfg_en_out)
    else $error("config enable longer than one cycle");
  chk_en_granted: assert property (cfg_en_out |-> $past(port_grant) && port_request)
    else $error("config enable without grant");
  chk_req_release: assert property ($fell(port_request) |-> $past(cfg_ready_in))
    else $error("request dropped before ready");
  chk_en_fields: assert property (cfg_en_out
    |-> cfg_we_out == !read_not_write && cfg_addr_out == access_address[CFG_ADDR_W-1:0])
    else $error("config address or direction wrong");
  chk_pass_fwd: assert property (1'b1 |=> xcvr_addr_out == $past(cfg_addr_in)
    && xcvr_en_out == $past(cfg_en_in) && cfg_rdata_out == $past(xcvr_rdata_in))
    else $error("pass-through not one cycle");

  cov_core_rd: cover property (read_ack && core_reg_select);
  cov_xcvr_wr: cover property (write_ack && xcvr_reg_select);
  cov_xcvr_rd: cover property (read_ack && xcvr_reg_select);
endmodule

// *** dv/test_training_and_xcvr_cfg_port.sv ***
`timescale 1ns/100ps
module test_training_and_xcvr_cfg_port;
  import tkp_pkg::*;

  logic                  mclk_in        = 1'b0;
  logic                  rst_n_in       = 1'b0;
  logic                  cmd_valid_in   = 1'b0;
  logic                  cmd_rnw_in     = 1'b0;
  logic                  cmd_core_in    = 1'b0;
  logic [ACC_ADDR_W-1:0] cmd_addr_in    = ADDR_RST;
  logic [WORD_W-1:0]     cmd_wdata_in   = WORD_RST;
  logic                  cmd_ready_out;
  logic                  rsp_valid_out;
  logic [WORD_W-1:0]     rsp_rdata_out;
  logic [CFG_ADDR_W-1:0] xcvr_addr_out;
  logic                  xcvr_en_out;
  logic [WORD_W-1:0]     xcvr_wdata_out;
  logic                  xcvr_we_out;
  logic [WORD_W-1:0]     xcvr_rdata_in  = WORD_RST;
  logic                  xcvr_ready_in  = 1'b0;
  logic [WORD_W-1:0]     core_ref [16];
  logic [WORD_W-1:0]     xcvr_ref [256];
  logic [WORD_W-1:0]     xv_mem   [256];
  logic [7:0]            xv_addr  = 8'h00;
  int                    xv_cnt   = 0;
  int                    err_count = 0;
  int                    cmp_count = 0;

  always #5 mclk_in = ~mclk_in;

  tkp_port_if u_tkp_port_if ();

  tkp_device u_tkp_device (
    .mclk_in        (mclk_in),
    .rst_n_in       (rst_n_in),
    .port_if        (u_tkp_port_if),
    .xcvr_addr_out  (xcvr_addr_out),
    .xcvr_en_out    (xcvr_en_out),
    .xcvr_wdata_out (xcvr_wdata_out),
    .xcvr_we_out    (xcvr_we_out),
    .xcvr_rdata_in  (xcvr_rdata_in),
    .xcvr_ready_in  (xcvr_ready_in)
  );

  tkp_trainer u_tkp_trainer (
    .mclk_in       (mclk_in),
    .rst_n_in      (rst_n_in),
    .port_if       (u_tkp_port_if),
    .cmd_valid_in  (cmd_valid_in),
    .cmd_rnw_in    (cmd_rnw_in),
    .cmd_core_in   (cmd_core_in),
    .cmd_addr_in   (cmd_addr_in),
    .cmd_wdata_in  (cmd_wdata_in),
    .cmd_ready_out (cmd_ready_out),
    .rsp_valid_out (rsp_valid_out),
    .rsp_rdata_out (rsp_rdata_out)
  );

  tkp_port_props u_tkp_port_props (
    .mclk_in         (mclk_in),
    .rst_n_in        (rst_n_in),
    .access_strobe   (u_tkp_port_if.access_strobe),
    .access_address  (u_tkp_port_if.access_address),
    .read_not_write  (u_tkp_port_if.read_not_write),
    .core_reg_select (u_tkp_port_if.core_reg_select),
    .xcvr_reg_select (u_tkp_port_if.xcvr_reg_select),
    .read_ack        (u_tkp_port_if.read_ack),
    .write_ack       (u_tkp_port_if.write_ack),
    .port_request    (u_tkp_port_if.port_request),
    .port_grant      (u_tkp_port_if.port_grant),
    .cfg_addr_out    (u_tkp_port_if.cfg_addr_out),
    .cfg_en_out      (u_tkp_port_if.cfg_en_out),
    .cfg_we_out      (u_tkp_port_if.cfg_we_out),
    .cfg_ready_in    (u_tkp_port_if.cfg_ready_in),
    .cfg_addr_in     (u_tkp_port_if.cfg_addr_in),
    .cfg_en_in       (u_tkp_port_if.cfg_en_in),
    .cfg_rdata_out   (u_tkp_port_if.cfg_rdata_out),
    .xcvr_addr_out   (xcvr_addr_out),
    .xcvr_en_out     (xcvr_en_out),
    .xcvr_rdata_in   (xcvr_rdata_in)
  );

  // ************************************************************
  // transceiver model: answers 1..4 cycles late, data scrambled when idle
  // ************************************************************
  always @(negedge mclk_in) begin
    if (xv_cnt == 1) begin
      xcvr_ready_in = 1'b1;
      xcvr_rdata_in = xv_mem[xv_addr];
    end else begin
      xcvr_ready_in = 1'b0;
      xcvr_rdata_in = ~xcvr_rdata_in;
    end
    if (xv_cnt != 0) xv_cnt--;
    if (xcvr_en_out === 1'b1) begin
      xv_addr = xcvr_addr_out[7:0];
      if (xcvr_we_out === 1'b1) xv_mem[xv_addr] = xcvr_wdata_out;
      xv_cnt = 1 + $urandom_range(3);
    end
  end

  // ************************************************************
  // checking and stimulus tasks
  // ************************************************************
  task automatic cmp_word(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: read word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic summarize();
    if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic do_reset();
    @(negedge mclk_in);
    rst_n_in = 1'b0;
    repeat (8) @(negedge mclk_in);
    rst_n_in = 1'b1;
    foreach (core_ref[i]) core_ref[i] = WORD_RST;
  endtask

  // one access through the trainer; reads compared against the bench copy
  task automatic run_cmd(input logic rnw, input logic core, input logic [ACC_ADDR_W-1:0] a,
                         input logic [WORD_W-1:0] wd);
    int n;
    logic [WORD_W-1:0] exp;
    exp = core ? core_ref[a[3:0]] : xcvr_ref[a[7:0]];
    if (!rnw && core) core_ref[a[3:0]] = wd;
    if (!rnw && !core) xcvr_ref[a[7:0]] = wd;
    @(negedge mclk_in);
    cmd_valid_in = 1'b1;
    cmd_rnw_in = rnw;
    cmd_core_in = core;
    cmd_addr_in = a;
    cmd_wdata_in = wd;
    n = 0;
    while (cmd_ready_out !== 1'b1 && n < 50) begin
      @(negedge mclk_in);
      n++;
    end
    @(negedge mclk_in);
    cmd_valid_in = 1'b0;
    n = 0;
    while (rsp_valid_out !== 1'b1 && n < 200) begin
      @(negedge mclk_in);
      n++;
    end
    cmp_bit(rsp_valid_out, 1'b1);
    cmp_bit(u_tkp_port_if.port_request, 1'b0);
    if (rnw) cmp_word(rsp_rdata_out, exp);
  endtask

  function automatic logic [ACC_ADDR_W-1:0] rnd_addr();
    return {5'($urandom), 8'h00, 8'($urandom)};
  endfunction

  initial begin
    foreach (xcvr_ref[i]) xcvr_ref[i] = WORD_RST;
    foreach (xv_mem[i]) xv_mem[i] = WORD_RST;
    void'($urandom(92581));
    do_reset();
    cmp_bit(u_tkp_port_if.port_request, 1'b0);
    // same index, different device field: the core store ignores the field
    run_cmd(1'b0, 1'b1, 21'h1F0005, 16'hFFFF);
    run_cmd(1'b1, 1'b1, 21'h010005, 16'h0000);
    run_cmd(1'b0, 1'b0, 21'h0300A5, 16'h5A5A);
    run_cmd(1'b1, 1'b0, 21'h0000A5, 16'h0000);
    run_cmd(1'b1, 1'b0, 21'h0000FF, 16'h0000);
    repeat (60) run_cmd(1'($urandom), 1'($urandom), rnd_addr(), 16'($urandom));
    // reset mid-run clears the core store, transceiver contents survive
    do_reset();
    run_cmd(1'b1, 1'b1, 21'h000005, 16'h0000);
    run_cmd(1'b1, 1'b0, 21'h0000A5, 16'h0000);
    summarize();
  end

  // limit far above the expected thousand cycles at most
  initial begin
    #400000;
    err_count++;
    summarize();
  end
endmodule
